// File: hw/bfm_fault_monitor.sv
// bfm_fault_monitor: operational fault monitors of a full-bridge gate driver
// assumes comparator inputs are synchronous to clock; flags clear on fault_clear
// assumes comparator hysteresis is done in the analog front end
// limitation: only the regulator low monitor can be masked
//
// How it works
// [R1] regulator low: flag, fault, gates off
// [R2] regulator recovery re-enables gates, releases fault
// [R3] gates held low until regulator first good
// [R4] mask disables the regulator low monitor
// [R5] regulator high: flag and fault only
// [R6] thermal warning: flag and fault only
// [R7] aux regulator low: flag and fault only
// [R8] aux regulator high: flag and fault only
// [R9] supply high: flag and fault only
// [R10] supply low: flag, fault, gates off
// [R11] active gate undervoltage sets own flag
// [R12] seven logic pins watched for overvoltage
// [R13] input pin overvoltage stops gates if enabled
// [R14] release only when all pins back low
// [R15] enable gates outputs; watchdog select bit
// [R16] first enable edge starts watchdog and outputs
// [R17] controller toggles enable before each timeout
// [R18] timeout: gates off, flag, fault
// [R19] next enable edge recovers after timeout
// [R20] all flags sticky until fault clear
// [R21] watchdog restarts on every enable edge
// [R22] fault output ORs active monitor states
`timescale 1ns/10ps
module bfm_fault_monitor #(
    parameter int unsigned TIMEOUT_CYCLES = bfm_pkg::ENABLE_TIMEOUT_CYCLES
) (
    input  wire logic       clock,                   // device clock
    input  wire logic       rst_n,                   // async reset, active low
    input  wire logic       clk_en,                  // freezes all state when low

    // phase control inputs
    input  wire logic       bridge_a_top_in,         // a top gate command
    input  wire logic       bridge_b_top_in_n,       // b top gate command, active low
    input  wire logic       bridge_a_bottom_in_n,    // a bottom gate command, active low
    input  wire logic       bridge_b_bottom_in,      // b bottom gate command
    input  wire logic       enable_in,               // enable pin level

    // comparator results, high while the condition is present
    input  wire logic       charge_reg_low_cmp,      // regulator below its turn-on level
    input  wire logic       charge_reg_high_cmp,     // regulator overvoltage
    input  wire logic       thermal_warn_cmp,        // junction temperature warning
    input  wire logic       aux_reg_low_cmp,         // logic regulator undervoltage
    input  wire logic       aux_reg_high_cmp,        // logic regulator overvoltage
    input  wire logic       supply_high_cmp,         // main supply overvoltage
    input  wire logic       supply_low_cmp,          // main supply undervoltage
    input  wire logic [3:0] gate_uv_cmp,             // per gate source undervoltage
    input  wire logic [6:0] pin_ov_cmp,              // per logic pin overvoltage

    // configuration
    input  wire logic       charge_reg_low_mask,     // disables regulator low monitor
    input  wire logic       stop_outputs_on_fault,   // input pin overvoltage stops gates
    input  wire logic       enable_wdog_select,      // 1 selects watchdog mode
    input  wire logic       fault_clear,             // clears all sticky flags

    // outputs
    output logic [3:0]      gate_out,                // a top, a bottom, b top, b bottom
    output logic            general_fault,           // any monitor fault active
    output logic            charge_reg_low_flag,     // sticky flags follow
    output logic            charge_reg_high_flag,
    output logic            thermal_warn_flag,
    output logic            aux_reg_low_flag,
    output logic            aux_reg_high_flag,
    output logic            supply_high_flag,
    output logic            supply_low_flag,
    output logic            a_top_gate_uv,
    output logic            a_bottom_gate_uv,
    output logic            b_top_gate_uv,
    output logic            b_bottom_gate_uv,
    output logic            logic_pin_overvolt_flag,
    output logic            enable_timeout_flag
);

    // all state in one struct
    // so register and next value stay in step
    typedef struct packed {
        logic [3:0]                 gate;        // registered gate drive
        logic                       fault;       // general fault
        logic                       reg_good;    // regulator has passed turn-on once
        logic                       en_prev;     // enable level last cycle
        logic                       en_valid;    // enable sampled once
        bfm_pkg::bfm_wd_state_t     wd;          // watchdog state
        logic [bfm_pkg::WDOG_W-1:0] wd_cnt;      // cycles since last enable edge
        logic [12:0]                flags;       // sticky flags
    } bfm_state_t;

    // flag indices inside the flag vector
    // supply and temperature monitors
    localparam int unsigned F_RL = 0;
    localparam int unsigned F_RH = 1;
    localparam int unsigned F_TW = 2;
    localparam int unsigned F_AL = 3;
    localparam int unsigned F_AH = 4;
    localparam int unsigned F_SH = 5;
    localparam int unsigned F_SL = 6;

    // gate, pin and watchdog monitors
    localparam int unsigned F_GU = 7;            // four gate flags from here
    localparam int unsigned F_LP = 11;
    localparam int unsigned F_ET = 12;

    // reset image: gates low, flags clear, watchdog idle
    localparam bfm_state_t STATE_RESET = '{
        gate:     bfm_pkg::GATE_RESET,
        fault:    bfm_pkg::FLAG_RESET,
        reg_good: 1'b0,
        en_prev:  1'b0,
        en_valid: 1'b0,
        wd:       bfm_pkg::BFM_WD_IDLE,
        wd_cnt:   '0,
        flags:    13'h0000
    };

    // the register and its next value
    bfm_state_t s_q;                             // registered state
    bfm_state_t s_d;                             // next state

    // sticky flag update: a new event wins over a clear in the same cycle
    // shared so no flag gets another priority
    function automatic logic sticky(input logic cur, input logic ev, input logic clr);
        sticky = ev | (cur & ~clr);
    endfunction

    // next state logic
    always_comb
    begin
        logic       rl_act;                      // regulator low monitor live
        logic       pin_in_ov;                   // overvoltage on an input pin
        logic       en_edge;                     // enable changed level
        logic       wd_ok;                       // watchdog lets gates follow
        logic       stop;                        // gates forced low
        logic [3:0] cmd;                         // phase command, active high
        logic [3:0] gate_uv_ev;                  // undervoltage on an active gate

        // every local first, so no latch
        s_d        = s_q;
        wd_ok      = 1'b0;
        stop       = 1'b0;
        rl_act     = charge_reg_low_cmp & ~charge_reg_low_mask;              // [R4]
        pin_in_ov  = |(pin_ov_cmp & bfm_pkg::INPUT_PIN_MASK);
        // no edge until the pin was seen once:
        // a pin high at reset release is no first edge
        en_edge    = s_q.en_valid & (enable_in ^ s_q.en_prev);

        // two phase pins are active low
        cmd        = 4'h0;
        cmd[bfm_pkg::GATE_A_TOP]    = bridge_a_top_in;
        cmd[bfm_pkg::GATE_A_BOTTOM] = ~bridge_a_bottom_in_n;
        cmd[bfm_pkg::GATE_B_TOP]    = ~bridge_b_top_in_n;
        cmd[bfm_pkg::GATE_B_BOTTOM] = bridge_b_bottom_in;
        // only a gate that is driven is checked
        gate_uv_ev = gate_uv_cmp & s_q.gate;                                 // [R11]
        s_d.en_prev = enable_in;
        s_d.en_valid = 1'b1;


        // regulator must pass turn-on before any gate may drive
        // never cleared: later dips go through rl_act
        if (!charge_reg_low_cmp)
        begin
            s_d.reg_good = 1'b1;                                             // [R3]
        end

        // enable watchdog; direct mode keeps it idle
        s_d.wd_cnt = s_q.wd_cnt;
        if (!enable_wdog_select)
        begin
            s_d.wd     = bfm_pkg::BFM_WD_IDLE;                               // [R15]
            s_d.wd_cnt = '0;
        end
        else
        begin
            unique case (s_q.wd)
                bfm_pkg::BFM_WD_IDLE:
                begin
                    // first edge arms the timer
                    if (en_edge)
                    begin
                        s_d.wd     = bfm_pkg::BFM_WD_RUN;                    // [R16]
                        s_d.wd_cnt = '0;
                    end
                end
                bfm_pkg::BFM_WD_RUN:
                begin
                    // any level change restarts the count
                    if (en_edge)
                    begin
                        s_d.wd_cnt = '0;                                     // [R21]
                    end
                    // count ran out with no edge
                    else if (s_q.wd_cnt >= TIMEOUT_CYCLES[bfm_pkg::WDOG_W-1:0] - 1'b1)
                    begin
                        s_d.wd = bfm_pkg::BFM_WD_TIMEOUT;                    // [R18]
                    end
                    else
                    begin
                        s_d.wd_cnt = s_q.wd_cnt + 1'b1;
                    end
                end
                bfm_pkg::BFM_WD_TIMEOUT:
                begin
                    // next edge recovers and restarts the timer
                    if (en_edge)
                    begin
                        s_d.wd     = bfm_pkg::BFM_WD_RUN;                    // [R19]
                        s_d.wd_cnt = '0;
                    end
                end
                default:
                begin
                    // spare code falls back to idle
                    s_d.wd = bfm_pkg::BFM_WD_IDLE;
                end
            endcase
        end
        // outputs follow commands only when armed and not timed out
        // direct mode leaves gating to the pin
        wd_ok = enable_wdog_select ? (s_q.wd == bfm_pkg::BFM_WD_RUN) : 1'b1; // [R16]

        // gate shutdown sources
        // any one forces all gates low
        stop = rl_act                                                        // [R1]
             | ~s_q.reg_good                                                 // [R3]
             | supply_low_cmp                                                // [R10]
             | (pin_in_ov & stop_outputs_on_fault)                           // [R13]
             | ~enable_in                                                    // [R15]
             | ~wd_ok;                                                       // [R18]
        // recovery is simply the shutdown source going away
        s_d.gate = stop ? 4'h0 : cmd;                                        // [R2]

        // fault is live while any monitor condition holds; diag pin counts too
        // it drops with its source; flags stay
        s_d.fault = rl_act | charge_reg_high_cmp | thermal_warn_cmp          // [R22]
                  | aux_reg_low_cmp | aux_reg_high_cmp                       // [R7]
                  | supply_high_cmp | supply_low_cmp                         // [R9]
                  | (|gate_uv_ev) | (|pin_ov_cmp)                            // [R14]
                  | (enable_wdog_select & (s_q.wd == bfm_pkg::BFM_WD_TIMEOUT)); // [R19]

        // sticky flags, cleared only by fault_clear
        s_d.flags[F_RL] = sticky(s_q.flags[F_RL], rl_act, fault_clear);      // [R20]
        s_d.flags[F_RH] = sticky(s_q.flags[F_RH], charge_reg_high_cmp, fault_clear); // [R5]
        s_d.flags[F_TW] = sticky(s_q.flags[F_TW], thermal_warn_cmp, fault_clear);    // [R6]
        s_d.flags[F_AL] = sticky(s_q.flags[F_AL], aux_reg_low_cmp, fault_clear);     // [R7]
        s_d.flags[F_AH] = sticky(s_q.flags[F_AH], aux_reg_high_cmp, fault_clear);    // [R8]
        s_d.flags[F_SH] = sticky(s_q.flags[F_SH], supply_high_cmp, fault_clear);     // [R9]
        s_d.flags[F_SL] = sticky(s_q.flags[F_SL], supply_low_cmp, fault_clear);      // [R10]

        // only gates driven last cycle
        for (int i = 0; i < 4; i++)
        begin
            s_d.flags[F_GU+i] = sticky(s_q.flags[F_GU+i], gate_uv_ev[i], fault_clear); // [R11]
        end
        // any of seven pins, diag included
        s_d.flags[F_LP] = sticky(s_q.flags[F_LP], |pin_ov_cmp, fault_clear);  // [R12]
        // same test as the move to timeout
        s_d.flags[F_ET] = sticky(s_q.flags[F_ET],                             // [R18]
            enable_wdog_select & (s_q.wd == bfm_pkg::BFM_WD_RUN) & ~en_edge
            & (s_q.wd_cnt >= TIMEOUT_CYCLES[bfm_pkg::WDOG_W-1:0] - 1'b1), fault_clear);
    end

    // state register, frozen while clk_en is low
    // reset image is constant only
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= STATE_RESET;
        end
        else if (clk_en)
        begin
            s_q <= s_d;
        end
    end

    // outputs come straight from the state register
    assign gate_out                = s_q.gate;
    assign general_fault           = s_q.fault;

    // supply and temperature flags
    assign charge_reg_low_flag     = s_q.flags[F_RL];
    assign charge_reg_high_flag    = s_q.flags[F_RH];
    assign thermal_warn_flag       = s_q.flags[F_TW];
    assign aux_reg_low_flag        = s_q.flags[F_AL];
    assign aux_reg_high_flag       = s_q.flags[F_AH];
    assign supply_high_flag        = s_q.flags[F_SH];
    assign supply_low_flag         = s_q.flags[F_SL];

    // per gate undervoltage flags
    assign a_top_gate_uv           = s_q.flags[F_GU+bfm_pkg::GATE_A_TOP];
    assign a_bottom_gate_uv        = s_q.flags[F_GU+bfm_pkg::GATE_A_BOTTOM];
    assign b_top_gate_uv           = s_q.flags[F_GU+bfm_pkg::GATE_B_TOP];
    assign b_bottom_gate_uv        = s_q.flags[F_GU+bfm_pkg::GATE_B_BOTTOM];

    // pin and watchdog flags
    assign logic_pin_overvolt_flag = s_q.flags[F_LP];
    assign enable_timeout_flag     = s_q.flags[F_ET];

endmodule // bfm_fault_monitor

// File: hw/bfm_pkg.sv
// bfm_pkg: constants for the bridge driver fault monitor block
// assumes a 40 MHz device clock and comparator levels already synchronous
package bfm_pkg;
    // clock period in ns
    localparam int unsigned CLK_PERIOD_NS = 25;
    // enable watchdog timeout in us (plain default; real value is trimmed elsewhere)
    localparam int unsigned ENABLE_TIMEOUT_TIME_US = 1000;
    // timeout in cycles, longest time so rounded down
    localparam int unsigned ENABLE_TIMEOUT_CYCLES =
        (ENABLE_TIMEOUT_TIME_US * 1000) / CLK_PERIOD_NS;
    // watchdog counter width
    localparam int unsigned WDOG_W = 32;
    // gate output bit positions
    localparam int unsigned GATE_A_TOP    = 0;
    localparam int unsigned GATE_A_BOTTOM = 1;
    localparam int unsigned GATE_B_TOP    = 2;
    localparam int unsigned GATE_B_BOTTOM = 3;
    localparam int unsigned NUM_GATES     = 4;
    // logic pin overvoltage comparator positions
    localparam int unsigned PIN_A_TOP     = 0;
    localparam int unsigned PIN_B_TOP     = 1;
    localparam int unsigned PIN_A_BOTTOM  = 2;
    localparam int unsigned PIN_B_BOTTOM  = 3;
    localparam int unsigned PIN_RESET     = 4;
    localparam int unsigned PIN_ENABLE    = 5;
    localparam int unsigned PIN_DIAG      = 6;
    localparam int unsigned NUM_PINS      = 7;
    // input pins only (everything except the diagnostic pin)
    localparam logic [6:0] INPUT_PIN_MASK = 7'h3F;
    // reset values
    localparam logic       FLAG_RESET     = 1'b0;
    localparam logic [3:0] GATE_RESET     = 4'h0;
    // enable watchdog states
    typedef enum logic [1:0] {
        BFM_WD_IDLE,
        BFM_WD_RUN,
        BFM_WD_TIMEOUT
    } bfm_wd_state_t;
endpackage : bfm_pkg

// File: verif/bfm_ctrl_model.sv
// bfm_ctrl_model: external controller driving enable and phase commands
// assumes the bench changes run, hold and cmd only at clock edges
`timescale 1ns/10ps
module bfm_ctrl_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       run,                  // toggle enable while high
    input  wire logic       hold,                 // enable level while stalled
    input  wire logic [7:0] period,               // cycles between toggles
    input  wire logic [3:0] cmd,                  // wanted gates, gate_out order
    output logic            enable_in,
    output logic            bridge_a_top_in,
    output logic            bridge_b_top_in_n,
    output logic            bridge_a_bottom_in_n,
    output logic            bridge_b_bottom_in
);
    logic [7:0] cnt_q;  // cycles since the last toggle
    // a stall freezes enable, which is how the bench provokes a timeout
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_in <= 1'b0;
            cnt_q     <= 8'h00;
        end
        else if (run && cnt_q >= period - 8'h01)
        begin
            enable_in <= ~enable_in;
            cnt_q     <= 8'h00;
        end
        else if (run)
            cnt_q <= cnt_q + 8'h01;
        else
        begin
            enable_in <= hold;
            cnt_q     <= 8'h00;
        end
    end
    // two of the four commands are active low at the pins
    assign bridge_a_top_in      = cmd[0];
    assign bridge_a_bottom_in_n = ~cmd[1];
    assign bridge_b_top_in_n    = ~cmd[2];
    assign bridge_b_bottom_in   = cmd[3];
endmodule // bfm_ctrl_model

// File: verif/bfm_fault_monitor_props.sv
// bfm_fault_monitor_props: port-level checks of the fault monitor
// assumes one clock domain; outputs are registered by the design
`timescale 1ns/10ps
module bfm_fault_monitor_props #(
    parameter int unsigned TIMEOUT_CYCLES = 16
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       clk_en,
    input wire logic       enable_in,
    input wire logic       charge_reg_low_cmp,
    input wire logic       thermal_warn_cmp,
    input wire logic       supply_low_cmp,
    input wire logic [3:0] gate_uv_cmp,
    input wire logic [6:0] pin_ov_cmp,
    input wire logic       charge_reg_low_mask,
    input wire logic       stop_outputs_on_fault,
    input wire logic       enable_wdog_select,
    input wire logic       fault_clear,
    input wire logic [3:0] gate_out,
    input wire logic       general_fault,
    input wire logic       charge_reg_low_flag,
    input wire logic       thermal_warn_flag,
    input wire logic       supply_low_flag,
    input wire logic       a_top_gate_uv,
    input wire logic       logic_pin_overvolt_flag,
    input wire logic       enable_timeout_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic        en_q;   // enable level at the last running edge
    logic        arm_q;  // watchdog armed by an edge in watchdog mode
    int unsigned cnt_q;  // running edges since the last enable change
    // saturating count so a long stall never wraps back to zero
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_q  <= 1'b0;
            arm_q <= 1'b0;
            cnt_q <= 0;
        end
        else if (clk_en)
        begin
            en_q  <= enable_in;
            arm_q <= arm_q | (enable_wdog_select & (enable_in ^ en_q));
            cnt_q <= (enable_in ^ en_q) ? 0 : ((cnt_q < 1000) ? cnt_q + 1 : cnt_q);
        end
    end
    property p_vru;
        clk_en && charge_reg_low_cmp && !charge_reg_low_mask |=>
            charge_reg_low_flag && general_fault && gate_out == 4'h0;
    endproperty
    a_vru: assert property (p_vru) else $error("regulator low not handled");
    property p_mask;
        clk_en && charge_reg_low_mask && !charge_reg_low_flag |=> !charge_reg_low_flag;
    endproperty
    a_mask: assert property (p_mask) else $error("masked monitor set a flag");
    property p_tw;
        clk_en && thermal_warn_cmp |=> thermal_warn_flag && general_fault;
    endproperty
    a_tw: assert property (p_tw) else $error("thermal warning missed");
    property p_vsu;
        clk_en && supply_low_cmp |=> supply_low_flag && general_fault && gate_out == 4'h0;
    endproperty
    a_vsu: assert property (p_vsu) else $error("supply low not handled");
    property p_uv;
        clk_en && gate_uv_cmp[0] && gate_out[0] |=> a_top_gate_uv && general_fault;
    endproperty
    a_uv: assert property (p_uv) else $error("gate undervoltage missed");
    property p_diag;
        clk_en && pin_ov_cmp[6] |=> logic_pin_overvolt_flag && general_fault;
    endproperty
    a_diag: assert property (p_diag) else $error("pin overvoltage missed");
    property p_stop;
        clk_en && stop_outputs_on_fault && (pin_ov_cmp[5:0] != 6'h00) |=> gate_out == 4'h0;
    endproperty
    a_stop: assert property (p_stop) else $error("input pin fault left gates on");
    property p_en;
        clk_en && !enable_in |=> gate_out == 4'h0;
    endproperty
    a_en: assert property (p_en) else $error("enable low left gates on");
    property p_sticky;
        $fell(supply_low_flag) |-> $past(fault_clear) && $past(clk_en);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag fell without clear");
    property p_wd;
        arm_q && enable_wdog_select && cnt_q == TIMEOUT_CYCLES + 2 |-> enable_timeout_flag;
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog did not time out");
    c_wd: cover property (enable_timeout_flag);
    c_vru: cover property (clk_en && charge_reg_low_cmp && !charge_reg_low_mask);
    c_stop: cover property (clk_en && stop_outputs_on_fault && pin_ov_cmp[0]);
endmodule // bfm_fault_monitor_props
bind bfm_fault_monitor bfm_fault_monitor_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (.*);

// File: verif/bfm_fault_monitor_test.sv
// bfm_fault_monitor_test: directed checks of the fault monitor block
// assumes bfm_ctrl_model as controller and a 40 MHz clock
`timescale 1ns/10ps
module bfm_fault_monitor_test;
    localparam int unsigned TC = 16;          // short watchdog for simulation
    logic       clock, rst_n, clk_en;         // clock, reset, run enable
    logic       run, hold, mask, stop, wsel;  // controller and configuration
    logic       clr;                          // sticky flag clear
    logic [6:0] mon, pin;                     // monitor and pin comparators
    logic [3:0] cmd, uv;                      // gate commands, gate undervoltage
    logic       en, a_t, b_tn, a_bn, b_b;     // controller pins
    wire  [6:0] fl, gv, fv, uvf, xf;          // observed outputs, zero padded
    int         miscompares, tests_run;
    assign gv[6:4]  = 3'h0;
    assign fv[6:1]  = 6'h00;
    assign uvf[6:4] = 3'h0;
    assign xf[6:2]  = 5'h00;
    bfm_ctrl_model u_ctrl (.clock(clock), .rst_n(rst_n), .run(run), .hold(hold),
        .period(8'h05), .cmd(cmd), .enable_in(en), .bridge_a_top_in(a_t),
        .bridge_b_top_in_n(b_tn), .bridge_a_bottom_in_n(a_bn), .bridge_b_bottom_in(b_b));
    bfm_fault_monitor #(.TIMEOUT_CYCLES(TC)) uut (.clock(clock), .rst_n(rst_n),
        .clk_en(clk_en), .bridge_a_top_in(a_t), .bridge_b_top_in_n(b_tn),
        .bridge_a_bottom_in_n(a_bn), .bridge_b_bottom_in(b_b), .enable_in(en),
        .charge_reg_low_cmp(mon[0]), .charge_reg_high_cmp(mon[1]), .thermal_warn_cmp(mon[2]),
        .aux_reg_low_cmp(mon[3]), .aux_reg_high_cmp(mon[4]), .supply_high_cmp(mon[5]),
        .supply_low_cmp(mon[6]), .gate_uv_cmp(uv), .pin_ov_cmp(pin),
        .charge_reg_low_mask(mask), .stop_outputs_on_fault(stop), .enable_wdog_select(wsel),
        .fault_clear(clr), .gate_out(gv[3:0]), .general_fault(fv[0]),
        .charge_reg_low_flag(fl[0]), .charge_reg_high_flag(fl[1]), .thermal_warn_flag(fl[2]),
        .aux_reg_low_flag(fl[3]), .aux_reg_high_flag(fl[4]), .supply_high_flag(fl[5]),
        .supply_low_flag(fl[6]), .a_top_gate_uv(uvf[0]), .a_bottom_gate_uv(uvf[1]),
        .b_top_gate_uv(uvf[2]), .b_bottom_gate_uv(uvf[3]),
        .logic_pin_overvolt_flag(xf[0]), .enable_timeout_flag(xf[1]));
    // free-running 40 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // wait a number of rising edges; only the main sequence uses it
    task go(input int n);
        repeat (n) @(posedge clock);
    endtask
    // compare one observed value and count it
    task chk(input string nm, input logic [6:0] e, input logic [6:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // single place where the run ends
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard: the sequence needs well under 400 cycles
    initial
    begin
        repeat (3000) @(posedge clock);
        miscompares++;
        summarize();
    end
    // main sequence; regulator starts low to cover power-up
    initial
    begin
        {rst_n, run, mask, wsel, clr, pin, uv} = '0;
        {clk_en, hold, stop} = 3'h7;
        mon = 7'h01;
        cmd = 4'h9;
        miscompares = 0;
        tests_run = 0;
        go(2); rst_n <= 1'b1;
        go(3); #1;
        chk("power-up gates", 7'h00, gv);
        chk("power-up flag", 7'h01, fl);
        go(1); mon <= 7'h00; go(3); #1;
        chk("recovered gates", 7'h09, gv);
        chk("recovered fault", 7'h00, fv);
        chk("held flag", 7'h01, fl);
        go(1); cmd <= 4'h6; go(2); #1;
        chk("swapped gates", 7'h06, gv);
        go(1); cmd <= 4'h9;
        // each supply and temperature monitor in turn
        for (int i = 0; i < 7; i++)
        begin
            go(1); clr <= 1'b1;
            go(1); clr <= 1'b0; mon <= 7'(7'h01 << i);
            go(2); #1;
            chk("monitor flags", 7'(7'h01 << i), fl);
            chk("monitor fault", 7'h01, fv);
            chk("monitor gates", (i == 0 || i == 6) ? 7'h00 : 7'h09, gv);
            go(1); mon <= 7'h00; go(3); #1;
            chk("release fault", 7'h00, fv);
            chk("release gates", 7'h09, gv);
            chk("sticky flags", 7'(7'h01 << i), fl);
        end
        go(1); clr <= 1'b1; mask <= 1'b1; mon <= 7'h01; go(3); #1;
        chk("masked flags", 7'h00, fl);
        chk("masked fault", 7'h00, fv);
        chk("masked gates", 7'h09, gv);
        go(1); clr <= 1'b0; mask <= 1'b0; mon <= 7'h00; uv <= 4'hF; go(2); #1;
        chk("active gate uv", 7'h09, uvf);
        chk("gate uv fault", 7'h01, fv);
        go(1); uv <= 4'h0; pin <= 7'h40; go(2); #1;
        chk("diag pin flag", 7'h01, xf);
        chk("diag pin gates", 7'h09, gv);
        go(1); pin <= 7'h41; go(2); #1;
        chk("input pin stop", 7'h00, gv);
        go(1); pin <= 7'h40; go(2); #1;
        chk("pin fault held", 7'h01, fv);
        go(1); pin <= 7'h00; stop <= 1'b0; go(2); #1;
        chk("pin release", 7'h00, fv);
        chk("pin gates", 7'h09, gv);
        go(1); pin <= 7'h20; clk_en <= 1'b0; go(3); #1;
        chk("frozen fault", 7'h00, fv);
        go(1); clk_en <= 1'b1; go(2); #1;
        chk("no stop gates", 7'h09, gv);
        chk("enable pin fault", 7'h01, fv);
        go(1); pin <= 7'h00; hold <= 1'b0; go(3); #1;
        chk("enable low gates", 7'h00, gv);
        // watchdog mode: enable high but unchanged keeps gates idle
        go(1); hold <= 1'b1; go(3); wsel <= 1'b1; clr <= 1'b1; go(3); #1;
        chk("unarmed gates", 7'h00, gv);
        go(1); clr <= 1'b0; run <= 1'b1;
        for (int k = 0; k < 40; k++)
        begin
            go(1); #1;
            chk("kept alive", 7'h00, xf);
        end
        go(1); run <= 1'b0; go(TC + 4); #1;
        chk("timeout flag", 7'h02, xf);
        chk("timeout fault", 7'h01, fv);
        chk("timeout gates", 7'h00, gv);
        go(1); hold <= 1'b0; go(4); #1;
        chk("revived fault", 7'h00, fv);
        go(1); hold <= 1'b1; go(3); #1;
        chk("revived gates", 7'h09, gv);
        chk("timeout sticky", 7'h02, xf);
        go(1); clr <= 1'b1; go(2); #1;
        chk("timeout cleared", 7'h00, xf);
        summarize();
    end
endmodule // bfm_fault_monitor_test
